// *** design/rcp_engine.sv ***
// 3D engine end: command registers, rectangle clear, swap control, colour path.
// Assumes software on a plain strobe port and pipeline status from same clock.
//
// Behaviour
// - Flush command flushes; bit 0 zeroes counters
// - Rectangle clear honours RGB and aux masks
// - Clear rectangle from primary clip, half open
// - Clear ignores clip enable and sense
// - Aux value, colour dithered or truncated
// - One clear can write colour and aux together
// - One request per swap, exchange at vsync
// - Request waits for idle pipe and interval
// - Interval bits 8:1 hold N-1
// - Stall at one or two pending swaps
// - Pending count up on increment, down done
// - Increment immediate, direct access only
// - RGB and alpha source selects
// - Local colour select with texture override
// - Local alpha select
// - RGB combiner zero, subtract, multiplier
// - RGB reverse, add local, invert
// - Alpha combiner mirrors RGB combiner
// - Bit 26 enables subpixel correction
// - Correction in place; host rewrites starts
// - Bit 27 enables texture and texel transfer
// - Fog enable and term selects
// - Fog bit 5 selects constant add
`timescale 1ns/1ns
module rcp_engine import rcp_pkg::*; #(
  parameter int CNT_W  = 24, // Pixel counter width
  parameter int PEND_W = 8   // Swap pending count width
) (
  // Clock and reset
  input  wire logic                  i_ref_clk,
  input  wire logic                  i_rst_n,
  // Software register port
  input  wire logic [REG_AW-1:0]     i_addr,
  input  wire logic [31:0]           i_wdata,
  input  wire logic                  i_wr,
  input  wire logic                  i_rd,
  input  wire logic                  i_direct,
  output logic      [31:0]           o_rdata,
  // Pipeline status and pixel events
  input  wire logic                  i_pipe_busy,
  input  wire logic [N_CNT-1:0]      i_cnt_inc,
  input  wire logic [7:0]            i_tex_alpha,
  input  wire logic                  i_texel_valid,
  output logic                       o_flush,
  output logic                       o_render_stall,
  output logic                       o_texel_take,
  // Rectangle clear pixel stream
  output logic                       o_fill_valid,
  input  wire logic                  i_fill_ready,
  output logic      [CLIP_CW-1:0]    o_fill_x,
  output logic      [CLIP_CW-1:0]    o_fill_y,
  output logic      [15:0]           o_fill_rgb,
  output logic      [15:0]           o_fill_aux,
  output logic                       o_fill_we_rgb,
  output logic                       o_fill_we_aux,
  // Colour path, fog and clip controls
  output logic      [1:0]            o_rgb_src_sel,
  output logic      [1:0]            o_alpha_src_sel,
  output logic                       o_rgb_local_source_sel,
  output logic      [1:0]            o_alpha_local_sel,
  output logic      [CP_COMB_W-1:0]  o_rgb_combiner,
  output logic      [CP_COMB_W-1:0]  o_alpha_combiner,
  output logic                       o_subpixel_en,
  output logic      [4:0]            o_setup_clks,
  output logic                       o_tex_en,
  output logic      [FOG_W-1:0]      o_atmos,
  output logic                       o_clip_en,
  output logic                       o_clip_sense,
  // Swap link
  rcp_swap_if.engine                 swap
);

  // ****************************************
  // Registers
  // ****************************************
  logic [CP_W-1:0]       color_path_q;    // Colour path control
  logic [FOG_W-1:0]      atmos_q;         // Fog control
  logic [FBM_W-1:0]      fb_mode_q;       // Masks and dither
  logic [23:0]           fill_color_q;    // 24-bit fill colour
  logic [15:0]           aux_fill_q;      // Aux fill value
  logic [31:0]           clip_x_q;        // Left/right, enable, sense
  logic [31:0]           clip_y_q;        // Low/high Y
  logic                  triple_q;        // Triple buffering
  logic [SWAP_IVL_W-1:0] ivl_q;           // Swap interval N-1
  logic [CNT_W-1:0]      cnt_q [N_CNT];   // Pixel counters
  logic [PEND_W-1:0]     pend_q;          // Swap pending count
  logic [PEND_W-1:0]     swaps_q;         // Swap commands not yet issued
  logic [SWAP_IVL_W:0]   vs_cnt_q;        // Vsyncs since last request
  logic                  swap_req_q;
  logic                  flush_q;
  logic                  local_sel_q;
  logic                  texel_q;
  logic [31:0]           rdata_q;
  rcp_fill_st_t          st_q;
  logic [CLIP_CW-1:0]    x_q;
  logic [CLIP_CW-1:0]    y_q;
  logic [15:0]           rgb_q;
  logic                  we_rgb_q;
  logic                  we_aux_q;

  // ****************************************
  // Write decode
  // ****************************************
  wire wr_nop   = i_wr && (i_addr == ADDR_FLUSH_CLR);
  wire wr_fill  = i_wr && (i_addr == ADDR_RECT_CLR);
  wire wr_swap  = i_wr && (i_addr == ADDR_SWAP);
  // Increments through the command queue are dropped: they must act at once
  wire wr_inc   = i_wr && (i_addr == ADDR_SWAP_INC) && i_direct;
  wire clear_ct = wr_nop && i_wdata[NOP_CLEAR];

  // Clip fields; enable and sense are not looked at by the clear
  wire [CLIP_CW-1:0] left  = clip_x_q[CLIP_LO_LSB +: CLIP_CW];
  wire [CLIP_CW-1:0] right = clip_x_q[CLIP_HI_LSB +: CLIP_CW];
  wire [CLIP_CW-1:0] lo_y  = clip_y_q[CLIP_LO_LSB +: CLIP_CW];
  wire [CLIP_CW-1:0] hi_y  = clip_y_q[CLIP_HI_LSB +: CLIP_CW];
  wire mask_rgb  = fb_mode_q[FBM_RGB_MASK];
  wire mask_aux  = fb_mode_q[FBM_AUX_MASK];
  wire fill_go   = wr_fill && (st_q == RCP_IDLE) && (left < right) && (lo_y < hi_y)
                   && (mask_rgb || mask_aux);
  wire step      = (st_q == RCP_FILL) && i_fill_ready;
  wire x_last    = (x_q == right - 1'b1);
  wire y_last    = (y_q == hi_y - 1'b1);
  wire fill_end  = step && x_last && y_last;
  wire [CLIP_CW-1:0] nx = fill_go ? left : (x_last ? left : x_q + 1'b1);
  wire [CLIP_CW-1:0] ny = fill_go ? lo_y : (x_last ? y_q + 1'b1 : y_q);

  // Swap issue: pipe empty, no clear running, interval met
  wire swap_ok   = (swaps_q != '0) && !i_pipe_busy && (st_q == RCP_IDLE)
                   && (vs_cnt_q > {1'b0, ivl_q});
  wire vs_full   = &vs_cnt_q;

  // ****************************************
  // Colour conversion, 24 to 16 bit
  // ****************************************
  // 2x2 ordered dither; saturating add keeps white from wrapping to black
  function automatic logic [15:0] to_565(input logic [23:0] c,
                                         input logic [1:0] ph,
                                         input logic dith);
    logic [1:0] d;
    logic [8:0] r;
    logic [8:0] g;
    logic [8:0] b;
    d = (ph == 2'h0) ? 2'h0 : (ph == 2'h1) ? 2'h2 : (ph == 2'h2) ? 2'h3 : 2'h1;
    r = {1'b0, c[23:16]} + (dith ? {6'h0, d, 1'b0} : 9'h0);
    g = {1'b0, c[15:8]}  + (dith ? {7'h0, d} : 9'h0);
    b = {1'b0, c[7:0]}   + (dith ? {6'h0, d, 1'b0} : 9'h0);
    to_565 = {(r[8] ? 5'h1F : r[7:3]), (g[8] ? 6'h3F : g[7:2]),
              (b[8] ? 5'h1F : b[7:3])};
  endfunction

  // ****************************************
  // Software registers
  // ****************************************
  // Control registers take plain writes
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      color_path_q <= CP_RST;
      atmos_q      <= FOG_RST;
      fb_mode_q    <= FBM_RST;
      fill_color_q <= 24'h0;
      aux_fill_q   <= 16'h0;
      clip_x_q     <= 32'h0;
      clip_y_q     <= 32'h0;
      triple_q     <= 1'b0;
      ivl_q        <= SWAP_IVL_RST;
    end else if (i_wr) begin
      if (i_addr == ADDR_COLOR_PATH) color_path_q <= i_wdata[CP_W-1:0];
      if (i_addr == ADDR_ATMOS)      atmos_q      <= i_wdata[FOG_W-1:0];
      if (i_addr == ADDR_FB_MODE)    fb_mode_q    <= i_wdata[FBM_W-1:0];
      if (i_addr == ADDR_FILL_COLOR) fill_color_q <= i_wdata[23:0];
      if (i_addr == ADDR_AUX_FILL)   aux_fill_q   <= i_wdata[15:0];
      if (i_addr == ADDR_CLIP_X)     clip_x_q     <= i_wdata;
      if (i_addr == ADDR_CLIP_Y)     clip_y_q     <= i_wdata;
      if (i_addr == ADDR_BUF_CFG)    triple_q     <= i_wdata[CFG_TRIPLE];
      // Bit 0 of the swap command is reserved and dropped
      if (i_addr == ADDR_SWAP)       ivl_q <= i_wdata[SWAP_IVL_LSB +: SWAP_IVL_W];
    end
  end

  // Pixel counters; a clear wins over a same-cycle increment
  always_ff @(posedge i_ref_clk) begin
    for (int i = 0; i < N_CNT; i++) begin
      if (!i_rst_n || clear_ct) begin
        cnt_q[i] <= '0;
      end else if (i_cnt_inc[i]) begin
        cnt_q[i] <= cnt_q[i] + 1'b1;
      end
    end
  end

  // ****************************************
  // Read port
  // ****************************************
  wire [2:0]  cidx   = 3'(i_addr[4:2]);
  wire        is_cnt = (i_addr[7:5] == 3'h2) && (i_addr[1:0] == 2'h0) && (cidx < 3'h5);
  wire [31:0] status = {21'h0, o_render_stall, (swaps_q != '0),
                        (st_q == RCP_FILL), pend_q};
  wire [31:0] rd_mux =
    (i_addr == ADDR_STATUS)     ? status :
    (i_addr == ADDR_COLOR_PATH) ? {4'h0, color_path_q} :
    (i_addr == ADDR_ATMOS)      ? {26'h0, atmos_q} :
    (i_addr == ADDR_FB_MODE)    ? {21'h0, fb_mode_q} :
    (i_addr == ADDR_FILL_COLOR) ? {8'h0, fill_color_q} :
    (i_addr == ADDR_AUX_FILL)   ? {16'h0, aux_fill_q} :
    (i_addr == ADDR_CLIP_X)     ? clip_x_q :
    (i_addr == ADDR_CLIP_Y)     ? clip_y_q :
    (i_addr == ADDR_BUF_CFG)    ? {31'h0, triple_q} :
    is_cnt                      ? 32'(cnt_q[cidx]) : 32'h0;

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n || !i_rd) rdata_q <= 32'h0;
    else                   rdata_q <= rd_mux;
  end

  // ****************************************
  // Rectangle clear walker
  // ****************************************
  // Walks left to right-1, low Y to high Y-1, stalling on the ready
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      st_q     <= RCP_IDLE;
      x_q      <= '0;
      y_q      <= '0;
      rgb_q    <= 16'h0;
      we_rgb_q <= 1'b0;
      we_aux_q <= 1'b0;
    end else begin
      case (st_q)
        RCP_IDLE: begin
          if (fill_go) begin
            st_q     <= RCP_FILL;
            we_rgb_q <= mask_rgb;
            we_aux_q <= mask_aux;
          end
        end
        default: begin
          if (fill_end) st_q <= RCP_IDLE;
        end
      endcase
      if (fill_go || (step && !fill_end)) begin
        x_q   <= nx;
        y_q   <= ny;
        rgb_q <= to_565(fill_color_q, {ny[0], nx[0]}, fb_mode_q[FBM_DITHER]);
      end
    end
  end

  // ****************************************
  // Swap control
  // ****************************************
  // Commands queue here until the pipe empties and the interval passes
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      swaps_q    <= '0;
      swap_req_q <= 1'b0;
      vs_cnt_q   <= '1;
      pend_q     <= '0;
      flush_q    <= 1'b0;
    end else begin
      swaps_q    <= swaps_q + PEND_W'(wr_swap) - PEND_W'(swap_ok);
      swap_req_q <= swap_ok;
      if (swap_ok)                   vs_cnt_q <= '0;
      else if (swap.vsync && !vs_full) vs_cnt_q <= vs_cnt_q + 1'b1;
      // Increment and completion in one cycle cancel out
      pend_q     <= pend_q + PEND_W'(wr_inc) - PEND_W'(swap.swap_done);
      flush_q    <= wr_nop;
    end
  end

  // ****************************************
  // Colour path
  // ****************************************
  // Texture alpha override is sampled each clock for the local select
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      local_sel_q <= 1'b0;
      texel_q     <= 1'b0;
    end else begin
      local_sel_q <= color_path_q[CP_LOCAL_OVR] ? i_tex_alpha[TEX_ALPHA_BIT]
                                                : color_path_q[CP_LOCAL_SEL];
      texel_q     <= color_path_q[CP_TEX_EN] && i_texel_valid;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign o_rdata         = rdata_q;
  assign o_flush         = flush_q;
  assign o_render_stall  = triple_q ? (pend_q >= PEND_W'(2)) : (pend_q != '0);
  assign o_texel_take    = texel_q;
  assign o_fill_valid    = (st_q == RCP_FILL);
  assign o_fill_x        = x_q;
  assign o_fill_y        = y_q;
  assign o_fill_rgb      = rgb_q;
  assign o_fill_aux      = aux_fill_q;
  assign o_fill_we_rgb   = we_rgb_q;
  assign o_fill_we_aux   = we_aux_q;
  assign o_rgb_src_sel   = color_path_q[CP_RGB_SEL +: 2];
  assign o_alpha_src_sel = color_path_q[CP_ALPHA_SEL +: 2];
  assign o_rgb_local_source_sel = local_sel_q;
  assign o_alpha_local_sel = color_path_q[CP_LOCAL_A +: 2];
  assign o_rgb_combiner    = color_path_q[CP_RGB_COMB +: CP_COMB_W];
  assign o_alpha_combiner  = color_path_q[CP_ALPHA_COMB +: CP_COMB_W];
  // Start values are corrected in place, so each triangle needs fresh ones
  assign o_subpixel_en   = color_path_q[CP_SUBPIX];
  assign o_setup_clks    = color_path_q[CP_SUBPIX] ? SETUP_SUBPIX : SETUP_FAST;
  assign o_tex_en        = color_path_q[CP_TEX_EN];
  assign o_atmos         = atmos_q;
  assign o_clip_en       = clip_x_q[CLIP_EN];
  assign o_clip_sense    = clip_x_q[CLIP_SENSE];
  assign swap.swap_req   = swap_req_q;

endmodule

// *** design/rcp_pkg.sv ***
// Constants shared by both ends of the render command and colour path.
// Assumes one core clock and byte addresses on the register port.
package rcp_pkg;

  // ****************************************
  // Register byte addresses
  // ****************************************
  localparam int            REG_AW          = 8;
  localparam logic [7:0]    ADDR_STATUS     = 8'h00; // Engine status, read only
  localparam logic [7:0]    ADDR_FLUSH_CLR  = 8'h04; // Flush and clear command
  localparam logic [7:0]    ADDR_RECT_CLR   = 8'h08; // Rectangle clear command
  localparam logic [7:0]    ADDR_SWAP       = 8'h0C; // Buffer swap command
  localparam logic [7:0]    ADDR_SWAP_INC   = 8'h10; // Swap pending increment
  localparam logic [7:0]    ADDR_COLOR_PATH = 8'h14; // Pixel colour path control
  localparam logic [7:0]    ADDR_ATMOS      = 8'h18; // Atmospheric control
  localparam logic [7:0]    ADDR_FB_MODE    = 8'h1C; // Frame buffer mode
  localparam logic [7:0]    ADDR_FILL_COLOR = 8'h20; // Fill colour, 24 bit
  localparam logic [7:0]    ADDR_AUX_FILL   = 8'h24; // Auxiliary fill value
  localparam logic [7:0]    ADDR_CLIP_X     = 8'h28; // Primary clip, left/right
  localparam logic [7:0]    ADDR_CLIP_Y     = 8'h2C; // Primary clip, low/high Y
  localparam logic [7:0]    ADDR_BUF_CFG    = 8'h30; // Buffering mode
  localparam logic [7:0]    ADDR_CNT_BASE   = 8'h40; // Five pixel counters

  // ****************************************
  // Field layouts
  // ****************************************
  localparam int CP_W          = 28; // Colour path width
  localparam int CP_RGB_SEL    = 0;  // Bits 1:0
  localparam int CP_ALPHA_SEL  = 2;  // Bits 3:2
  localparam int CP_LOCAL_SEL  = 4;
  localparam int CP_LOCAL_A    = 5;  // Bits 6:5
  localparam int CP_LOCAL_OVR  = 7;
  localparam int CP_RGB_COMB   = 8;  // Bits 16:8
  localparam int CP_ALPHA_COMB = 17; // Bits 25:17
  localparam int CP_COMB_W     = 9;
  localparam int CP_SUBPIX     = 26;
  localparam int CP_TEX_EN     = 27;
  localparam int TEX_ALPHA_BIT = 7;
  localparam int FOG_W         = 6;
  localparam int FBM_W         = 11;
  localparam int FBM_DITHER    = 8;
  localparam int FBM_RGB_MASK  = 9;
  localparam int FBM_AUX_MASK  = 10;
  localparam int NOP_CLEAR     = 0;
  localparam int SWAP_IVL_LSB  = 1;  // Bits 8:1
  localparam int SWAP_IVL_W    = 8;
  localparam int CLIP_CW       = 10;
  localparam int CLIP_HI_LSB   = 0;
  localparam int CLIP_LO_LSB   = 16;
  localparam int CLIP_SENSE    = 30;
  localparam int CLIP_EN       = 31;
  localparam int CFG_TRIPLE    = 0;
  localparam int ST_FILL_BUSY  = 8;
  localparam int ST_SWAP_WAIT  = 9;
  localparam int ST_STALL      = 10;
  localparam int N_CNT         = 5;

  // ****************************************
  // Reset values and timing counts
  // ****************************************
  localparam logic [CP_W-1:0]       CP_RST       = 28'h0;
  localparam logic [FOG_W-1:0]      FOG_RST      = 6'h0;
  localparam logic [FBM_W-1:0]      FBM_RST      = 11'h0;
  localparam logic [SWAP_IVL_W-1:0] SWAP_IVL_RST = 8'h00;
  localparam logic [4:0]            SETUP_FAST   = 5'h07; // Setup clocks, plain
  localparam logic [4:0]            SETUP_SUBPIX = 5'h10; // Setup clocks, corrected

  // ****************************************
  // Rectangle clear states
  // ****************************************
  typedef enum logic {
    RCP_IDLE = 1'b0,
    RCP_FILL = 1'b1
  } rcp_fill_st_t;

endpackage

// *** design/rcp_swap_if.sv ***
// Swap link between the 3D engine and the video refresh engine.
// Assumes both ends run on the same core clock; all signals are pulses.
`timescale 1ns/1ns
interface rcp_swap_if;
  logic swap_req;  // One request per issued swap
  logic vsync;     // Vertical sync period start
  logic swap_done; // Buffers exchanged
  modport engine  (output swap_req, input vsync, input swap_done);
  modport refresh (input swap_req, output vsync, output swap_done);
endinterface

// *** design/rcp_refresh.sv ***
// Video refresh end: takes swap requests and exchanges buffers at vsync.
// Assumes the display timing gives a one-cycle vsync pulse on the core clock.
`timescale 1ns/1ns
module rcp_refresh import rcp_pkg::*; (
  // Clock and reset
  input  wire logic       i_ref_clk,
  input  wire logic       i_rst_n,
  // Display timing side
  input  wire logic       i_vsync,
  input  wire logic       i_triple,
  output logic [1:0]      o_display_buf,
  // Swap link
  rcp_swap_if.refresh     swap
);

  // ****************************************
  // State
  // ****************************************
  logic [1:0] req_q;   // Requests waiting for vsync
  logic [1:0] buf_q;   // Buffer on display
  logic       done_q;  // Swap done pulse
  logic       vs_q;    // Vsync forwarded to the engine

  wire take = i_vsync && (req_q != 2'h0);
  wire [1:0] buf_nx = (i_triple && buf_q != 2'h2) ? buf_q + 2'h1 :
                      (!i_triple && buf_q == 2'h0) ? 2'h1 : 2'h0;

  // ****************************************
  // Swap at next vsync
  // ****************************************
  // A request in the vsync cycle itself still counts; it waits a frame
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      req_q  <= 2'h0;
      buf_q  <= 2'h0;
      done_q <= 1'b0;
      vs_q   <= 1'b0;
    end else begin
      req_q  <= req_q + {1'b0, swap.swap_req} - {1'b0, take};
      if (take) buf_q <= buf_nx;
      done_q <= take;
      vs_q   <= i_vsync;
    end
  end

  assign o_display_buf  = buf_q;
  assign swap.swap_done = done_q;
  assign swap.vsync     = vs_q;

endmodule

// *** sim/rcp_swap_chk.sv ***
// Checker for the swap link between the two ends.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ns
module rcp_swap_chk (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  // Link signals
  input wire logic swap_req,
  input wire logic vsync,
  input wire logic swap_done
);
  logic [3:0] outst_q; // Requests not yet answered
  logic       seen_q;  // Vsync since last request; set at reset, first swap may go at once
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_rst_n);
  // Shadow of the link state
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      outst_q <= 4'h0;
      seen_q  <= 1'b1;
    end else begin
      outst_q <= outst_q + 4'(swap_req) - 4'(swap_done);
      // A vsync in the request's own cycle already counts toward the next interval
      seen_q  <= vsync || (!swap_req && seen_q);
    end
  end
  a_done_at_vsync: assert property (swap_done |-> vsync)
    else $error("swap done off vsync");
  a_done_needs_req: assert property (swap_done |-> outst_q != 4'h0)
    else $error("swap done with no request");
  a_vsync_swaps: assert property (vsync && $past(outst_q) != 4'h0 |-> swap_done)
    else $error("pending swap missed its vsync");
  a_req_after_vsync: assert property (swap_req |-> seen_q)
    else $error("swap request without a vsync");
  a_req_pulse: assert property (swap_req |=> !swap_req)
    else $error("swap request longer than a cycle");
  a_done_pulse: assert property (swap_done |=> !swap_done)
    else $error("swap done longer than a cycle");
  a_vsync_pulse: assert property (vsync |=> !vsync)
    else $error("link vsync longer than a cycle");
  a_reset_quiet: assert property (disable iff (1'b0) !i_rst_n |=> !swap_req && !swap_done)
    else $error("link active in reset");
endmodule

// *** sim/render_cmd_color_path_tb.sv ***
// Bench: both ends joined by the swap link, checker beside it.
// Assumes the design package and a 100 MHz core clock.
`timescale 1ns/1ns
module render_cmd_color_path_tb import rcp_pkg::*; ;
  logic i_ref_clk = 1'b0, i_rst_n = 1'b0, i_wr = 1'b0, i_rd = 1'b0, i_direct = 1'b1;
  logic i_pipe_busy = 1'b1, i_texel_valid = 1'b1, i_fill_ready = 1'b0, i_vsync = 1'b0;
  logic i_triple = 1'b0, rd_d = 1'b0;
  logic [7:0] i_addr = 8'h00, i_tex_alpha = 8'h00;
  logic [31:0] i_wdata = 32'h0, o_rdata, v;
  logic [4:0] i_cnt_inc = 5'h00, o_setup_clks;
  logic o_flush, o_render_stall, o_texel_take, o_fill_valid, o_fill_we_rgb, o_fill_we_aux;
  logic o_rgb_local_source_sel, o_subpixel_en, o_tex_en, o_clip_en, o_clip_sense;
  logic [9:0] o_fill_x, o_fill_y;
  logic [15:0] o_fill_rgb, o_fill_aux;
  logic [1:0] o_rgb_src_sel, o_alpha_src_sel, o_alpha_local_sel, o_display_buf;
  logic [8:0] o_rgb_combiner, o_alpha_combiner;
  logic [5:0] o_atmos;
  logic [31:0] exp_q[$]; // Expected read data
  logic [35:0] fq[$];    // Expected fill pixels
  integer seed = 32'hE0205816, err_count = 0, compares = 0;
  int cyc = 0, vs_cnt = 0, gap = 0, req_cnt = 0, done_cnt = 0;
  wire [25:0] cp_out = {o_tex_en, o_subpixel_en, o_alpha_combiner, o_rgb_combiner,
    o_alpha_local_sel, o_alpha_src_sel, o_rgb_src_sel};
  rcp_swap_if sw ();
  rcp_engine rcp_engine_inst (.i_ref_clk, .i_rst_n, .i_addr, .i_wdata, .i_wr, .i_rd, .i_direct,
    .o_rdata, .i_pipe_busy, .i_cnt_inc, .i_tex_alpha, .i_texel_valid, .o_flush, .o_render_stall,
    .o_texel_take, .o_fill_valid, .i_fill_ready, .o_fill_x, .o_fill_y, .o_fill_rgb, .o_fill_aux,
    .o_fill_we_rgb, .o_fill_we_aux, .o_rgb_src_sel, .o_alpha_src_sel, .o_rgb_local_source_sel,
    .o_alpha_local_sel, .o_rgb_combiner, .o_alpha_combiner, .o_subpixel_en, .o_setup_clks,
    .o_tex_en, .o_atmos, .o_clip_en, .o_clip_sense, .swap(sw.engine));
  rcp_refresh rcp_refresh_inst (.i_ref_clk, .i_rst_n, .i_vsync, .i_triple, .o_display_buf,
    .swap(sw.refresh));
  rcp_swap_chk rcp_swap_chk_inst (.i_ref_clk, .i_rst_n, .swap_req(sw.swap_req),
    .vsync(sw.vsync), .swap_done(sw.swap_done));
  always #5 i_ref_clk = ~i_ref_clk;
  // Display timing and a sink that stalls at random
  always @(posedge i_ref_clk) begin
    cyc <= cyc + 1;
    i_vsync <= (cyc % 16 == 0);
    i_fill_ready <= 1'($random(seed));
  end
  task automatic check(input logic [47:0] seen, input logic [47:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: saw %0h, expected %0h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_ref_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_ref_clk);
    i_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge i_ref_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    exp_q.push_back(e);
    @(posedge i_ref_clk);
    i_rd <= 1'b0;
    #1;
  endtask
  task automatic test_done();
    $display("Compares %0d, mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Result watcher: takes the oldest note whenever a result shows
  always @(posedge i_ref_clk) begin
    if (rd_d) check(o_rdata, exp_q.pop_front());
    if (o_fill_valid && i_fill_ready) check({o_fill_x, o_fill_y, o_fill_rgb}, fq.pop_front());
    if (sw.swap_req) begin
      gap = vs_cnt;
      vs_cnt = 0;
      req_cnt++;
    end
    if (i_vsync) vs_cnt++;
    if (sw.swap_done) done_cnt++;
    rd_d <= i_rd;
  end
  initial begin
    #100000;
    err_count++;
    test_done();
  end
  initial begin
    repeat (5) @(posedge i_ref_clk);
    i_rst_n <= 1'b1;
    rd(ADDR_COLOR_PATH, 32'h0);
    rd(ADDR_ATMOS, 32'h0);
    rd(8'h3C, 32'h0);
    check(o_setup_clks, 5'h07);
    @(posedge i_ref_clk) i_cnt_inc <= 5'h1F;
    repeat (3) @(posedge i_ref_clk);
    i_cnt_inc <= 5'h00;
    for (int k = 0; k < 2; k++) begin
      wr(ADDR_FLUSH_CLR, k);
      check(o_flush, 1'b1);
      rd(ADDR_CNT_BASE + 8'h10, k ? 32'h0 : 32'h3);
    end
    for (int k = 0; k < 6; k++) begin
      v = $random(seed) & 32'h0FFFFFFF;
      v[7] = k[0];
      i_tex_alpha <= 8'($random(seed));
      wr(ADDR_COLOR_PATH, v);
      wr(ADDR_ATMOS, v & 32'h3F);
      check(cp_out, {v[27:8], v[6:5], v[3:0]});
      check(o_setup_clks, v[26] ? 5'h10 : 5'h07);
      check(o_atmos, v[5:0]);
      check(o_rgb_local_source_sel, v[7] ? i_tex_alpha[7] : v[4]);
      check(o_texel_take, v[27]);
      rd(ADDR_COLOR_PATH, v);
    end
    wr(ADDR_FILL_COLOR, 32'h00FF8040);
    wr(ADDR_AUX_FILL, 32'h1234);
    wr(ADDR_CLIP_X, 32'hC0010003);
    wr(ADDR_CLIP_Y, 32'h00020004);
    check({o_clip_en, o_clip_sense}, 2'h3);
    for (int m = 0; m < 4; m++) begin
      // Last pass: dark colour, so the 2x2 dither shows against truncation
      if (m == 3) wr(ADDR_FILL_COLOR, 32'h00060306);
      wr(ADDR_FB_MODE, m == 3 ? 32'h300 : m << 9);
      for (int p = 0; p < 4 && m > 0; p++) begin
        fq.push_back({10'(1 + p % 2), 10'(2 + p / 2),
                      m == 3 ? (p == 1 ? 16'h0000 : 16'h0821) : 16'hFC08});
      end
      wr(ADDR_RECT_CLR, 32'h0);
      check(o_fill_valid, m > 0);
      check({o_fill_we_aux, o_fill_we_rgb, o_fill_aux}, {m == 2, m[0], 16'h1234});
      for (int i = 0; i < 60 && o_fill_valid; i++) @(posedge i_ref_clk) #1;
      check(fq.size(), 0);
    end
    wr(ADDR_CLIP_X, 32'h00030003);
    wr(ADDR_RECT_CLR, 32'h0);
    check(o_fill_valid, 1'b0);
    wr(ADDR_SWAP_INC, 32'h1);
    check(o_render_stall, 1'b1);
    i_direct <= 1'b0;
    wr(ADDR_SWAP_INC, 32'h1);
    i_direct <= 1'b1;
    rd(ADDR_STATUS, 32'h401);
    i_triple <= 1'b1;
    wr(ADDR_BUF_CFG, 32'h1);
    check(o_render_stall, 1'b0);
    wr(ADDR_SWAP_INC, 32'h1);
    wr(ADDR_SWAP, 32'h4);
    rd(ADDR_STATUS, 32'h602);
    repeat (40) @(posedge i_ref_clk);
    check(req_cnt, 0);
    while (cyc % 16 != 4) @(posedge i_ref_clk);
    i_pipe_busy <= 1'b0;
    for (int s = 1; s < 3; s++) begin
      for (int i = 0; i < 200 && done_cnt < s; i++) @(posedge i_ref_clk) #1;
      check(o_display_buf, s);
      rd(ADDR_STATUS, s == 1 ? 32'h1 : 32'h0);
      if (s == 1) wr(ADDR_SWAP, 32'h4);
    end
    check(gap, 3);
    check(req_cnt, 2);
    test_done();
  end
endmodule
